// File: core/lcs_pkg.sv
// shared constants, enumerations and carriers of the charge sequencer
package lcs_pkg;

	// ************************************************
	// clock and timing
	// ************************************************
	localparam longint unsigned CLK_HZ          = 64'd125_000_000; // core clock rate
	localparam longint unsigned QUAL_TIME_S     = 64'd1;           // qualification pause, s
	localparam longint unsigned SUPPLY_TIME_S   = 64'd1;           // supply settle time, s
	localparam longint unsigned CHECK_TIME_S    = 64'd1;           // end-of-charge pause, s
	localparam longint unsigned HOUR_TIME_S     = 64'd3600;        // conditioning / top-off, s
	localparam longint unsigned BLINK_FREQ_MHZ  = 64'd800;         // indicator pulse, mHz
	localparam longint unsigned QUAL_CYCLES     = QUAL_TIME_S * CLK_HZ;
	localparam longint unsigned SUPPLY_CYCLES   = SUPPLY_TIME_S * CLK_HZ;
	localparam longint unsigned CHECK_CYCLES    = CHECK_TIME_S * CLK_HZ;
	localparam longint unsigned HOUR_CYCLES     = HOUR_TIME_S * CLK_HZ;
	localparam longint unsigned BLINK_HALF_CYCLES = (CLK_HZ * 64'd1000) / (64'd2 * BLINK_FREQ_MHZ);
	localparam int              TIMER_W         = 40;              // holds one hour of cycles

	// ************************************************
	// reset values
	// ************************************************
	localparam logic SYNC_RST  = 1'b0; // synchroniser stages
	localparam logic GATE_RST  = 1'b0; // pass gate off
	localparam logic OE_N_RST  = 1'b1; // indicators released
	localparam logic BLINK_RST = 1'b1; // blink phase

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [1:0] {VOUT_4V20, VOUT_4V10, VOUT_4V09, VOUT_3V84} lcs_vout_e;
	typedef enum logic [1:0] {ISENSE_50MV, ISENSE_500MV, ISENSE_900MV} lcs_isense_e;
	typedef enum logic [3:0] {
		ST_RESET, ST_STANDBY, ST_QUALIFY, ST_CONDITION, ST_COND_FAIL, ST_FAST,
		ST_CHECK, ST_DEFECT, ST_TOPOFF, ST_MONITOR, ST_FAULT
	} lcs_state_e;

	// digital control pins
	typedef struct packed {
		logic enable;          // pack present
		logic boost;           // current boost request
		logic voltage_select;  // high: 4.2 V family
		logic charge_pause_n;  // low halts charging
	} lcs_pins_s;

	// comparator flags from the analog loop
	typedef struct packed {
		logic supply_ok;        // supply above 3.4 V
		logic bat_le_2v50;      // battery at or below 2.5 V
		logic bat_ge_2v55;      // battery at or above 2.55 V
		logic gross_overcharge; // battery grossly overcharged
		logic bat_le_float;     // battery decayed to monitor target
		logic sense_le_40mv;    // sense voltage at or below 40 mV
		logic sense_gt_1v;      // sense voltage above 1 V
		logic rfv_gt_3v65;      // resistance-free voltage above 3.65 V
		logic over_voltage;     // battery above selected threshold
	} lcs_cmp_s;

endpackage

// File: core/lcs_sequencer.sv
// charge sequencer top: state machine, timers, indicators and targets
//
// Summary of operation
// - stay in standby while enable and boost low
// - boost overrides; refused at low battery or paused
// - boost mode drives both indicators low
// - standby target 4.2V or 4.1V by select
// - standby: gate off, indicators released
// - enable: indicator low, one-second gate-off qualification
// - overcharged at qualification: gate off, both blink
// - below 2.55V: conditioning at 4.1V, 50mV
// - conditioning limit one hour, then first blinks
// - above 2.55V go fast; first low, second released
// - fast charge 0.5V sense limit, 4.2V or 4.1V target by select
// - at 40mV gate off one second, check
// - low resistance-free voltage: gate off, first blinks
// - good voltage: top-off, first released, second low
// - one hour top-off, then gate off, monitor
// - monitor float target; decay returns to fast
// - overvoltage or overcurrent in a charge cycle: gate off, both blink
// - fault left only when enable falls
// - pause input low forces gate off
// - overvoltage threshold 4.3V or 4.4V by select
// - reset until supply good one second
// - boost raises sense target to 0.9V
`timescale 1ns/1ps
module lcs_sequencer
	import lcs_pkg::*;
#(
	parameter logic [TIMER_W-1:0] P_QUAL_CYCLES   = TIMER_W'(QUAL_CYCLES),      // qualification
	parameter logic [TIMER_W-1:0] P_SUPPLY_CYCLES = TIMER_W'(SUPPLY_CYCLES),    // supply settle
	parameter logic [TIMER_W-1:0] P_CHECK_CYCLES  = TIMER_W'(CHECK_CYCLES),     // end-of-charge
	parameter logic [TIMER_W-1:0] P_HOUR_CYCLES   = TIMER_W'(HOUR_CYCLES),      // long intervals
	parameter logic [TIMER_W-1:0] P_BLINK_CYCLES  = TIMER_W'(BLINK_HALF_CYCLES) // half blink
) (
	input  wire logic        i_clock,                 // core clock, 125 MHz
	input  wire logic        i_arst_n,                // power-on reset, active low
	input  wire lcs_pins_s   i_pins,                  // digital control pins
	input  wire lcs_cmp_s    i_cmp,                   // comparator flags
	output logic             o_pass_gate_drive,       // pass gate enable
	output lcs_vout_e        o_vout_sel,              // output voltage target
	output lcs_isense_e      o_isense_sel,            // sense voltage target
	output logic             o_ov_high,               // high: 4.4 V threshold
	output logic             o_charge_indicator,      // open-drain level, always low
	output logic             o_charge_indicator_oe_n, // low while pulled down
	output logic             o_full_indicator,        // open-drain level, always low
	output logic             o_full_indicator_oe_n,   // low while pulled down
	output lcs_state_e       o_mode                   // current sequencer state
);
	// ************************************************
	// checks and synchronisers
	// ************************************************
	localparam int SYNC_W = $bits(lcs_pins_s) + $bits(lcs_cmp_s);

	if (P_QUAL_CYCLES == '0 || P_SUPPLY_CYCLES == '0 || P_CHECK_CYCLES == '0 ||
		P_HOUR_CYCLES == '0 || P_BLINK_CYCLES == '0) begin : g_chk
		$error("lcs_sequencer interval counts must be at least one");
	end

	lcs_pins_s pin_s; // synchronised pins
	lcs_cmp_s  cmp_s; // synchronised flags

	// every pin and comparator flag crosses two flops first
	lcs_sync #(.W(SYNC_W)) u_sync (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_async  ({i_pins, i_cmp}),
		.o_sync   ({pin_s, cmp_s})
	);

	// ************************************************
	// state and helpers
	// ************************************************
	lcs_state_e         state_q;      // sequencer state
	lcs_state_e         state_d;      // next state
	logic               boost_q;      // boost mode active
	logic               boost_d;      // next boost
	logic               paused_q;     // pause seen in this cycle of charge
	logic               paused_d;     // next pause memory
	logic               armed_q;      // supply timer loaded once
	logic               blink_q;      // 0.8 Hz phase, low pulls indicator
	logic [TIMER_W-1:0] blink_cnt_q;  // half-period counter
	logic               tmr_load;     // restart interval timer
	logic [TIMER_W-1:0] tmr_value;    // interval to load
	logic               tmr_run;      // interval timer advances
	logic               tmr_done;     // interval elapsed
	logic               fault_hit;    // protection trip
	logic               in_cycle;     // a charge cycle is under way
	logic               gate_on;      // pass gate wanted
	logic               chg_low;      // first indicator pulled
	logic               full_low;     // second indicator pulled
	lcs_vout_e          vout_d;       // next voltage target
	lcs_isense_e        isense_d;     // next sense target

	// states that belong to an enabled charge cycle
	function automatic logic is_cycle(input lcs_state_e st);
		is_cycle = (st == ST_QUALIFY) || (st == ST_CONDITION) || (st == ST_FAST) ||
			(st == ST_CHECK) || (st == ST_TOPOFF) || (st == ST_MONITOR);
	endfunction

	// indicator pull for a state: solid low or the blink phase
	function automatic logic pull(input logic solid, input logic blinking, input logic ph);
		pull = solid | (blinking & ~ph);
	endfunction

	assign in_cycle = is_cycle(state_q);
	// protection is watched only in charge-cycle states, not under boost outside them
	assign fault_hit = in_cycle && (cmp_s.over_voltage || cmp_s.sense_gt_1v);
	// pause memory: set wins over the standby clear
	assign paused_d = (in_cycle && !pin_s.charge_pause_n) ||
		(paused_q && state_q != ST_STANDBY);
	// boost may start in any state but reset and fault, except at a deep battery or after a pause
	// a protection trip in this very cycle must not let boost hold the gate on
	assign boost_d = pin_s.boost && !cmp_s.bat_le_2v50 && !paused_q && !fault_hit &&
		state_q != ST_RESET && state_q != ST_FAULT;
	// intervals freeze while paused or boosted; supply timer needs a good supply
	assign tmr_run = (state_q == ST_RESET) ? cmp_s.supply_ok :
		(pin_s.charge_pause_n && !boost_q);

	// ************************************************
	// next state
	// ************************************************
	// next-state and timer load decode
	always_comb begin
		state_d   = state_q;
		tmr_load  = 1'b0;
		tmr_value = P_HOUR_CYCLES;
		if (state_q == ST_RESET) begin
			// hold reset until the supply has been good one second
			if (!cmp_s.supply_ok || !armed_q) begin
				tmr_load  = 1'b1;
				tmr_value = P_SUPPLY_CYCLES;
			end else if (tmr_done) begin
				state_d = ST_STANDBY;
			end
		end else if (!pin_s.enable) begin
			state_d = ST_STANDBY;
		end else if (fault_hit) begin
			state_d = ST_FAULT;
		end else if (!boost_q && pin_s.charge_pause_n) begin
			// a pause holds the sequence: with no current the taper flag would lie
			case (state_q)
				ST_STANDBY: begin
					// pack present starts qualification
					state_d   = ST_QUALIFY;
					tmr_load  = 1'b1;
					tmr_value = P_QUAL_CYCLES;
				end
				ST_QUALIFY: begin
					if (tmr_done) begin
						if (cmp_s.gross_overcharge) begin
							state_d = ST_FAULT;
						end else if (cmp_s.bat_ge_2v55) begin
							state_d = ST_FAST;
						end else begin
							state_d  = ST_CONDITION;
							tmr_load = 1'b1;
						end
					end
				end
				ST_CONDITION: begin
					if (cmp_s.bat_ge_2v55) begin
						state_d = ST_FAST;
					end else if (tmr_done) begin
						state_d = ST_COND_FAIL;
					end
				end
				ST_FAST: begin
					// charge current tapered: pause and measure
					if (cmp_s.sense_le_40mv) begin
						state_d   = ST_CHECK;
						tmr_load  = 1'b1;
						tmr_value = P_CHECK_CYCLES;
					end
				end
				ST_CHECK: begin
					if (tmr_done) begin
						if (cmp_s.rfv_gt_3v65) begin
							state_d  = ST_TOPOFF;
							tmr_load = 1'b1;
						end else begin
							state_d = ST_DEFECT;
						end
					end
				end
				ST_TOPOFF: begin
					if (tmr_done) begin
						state_d = ST_MONITOR;
					end
				end
				ST_MONITOR: begin
					if (cmp_s.bat_le_float) begin
						state_d = ST_FAST;
					end
				end
				default: begin
					// fault and defect states wait for enable to fall
					state_d = state_q;
				end
			endcase
		end
	end

	lcs_timer #(.W(TIMER_W)) u_timer (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_load   (tmr_load),
		.i_value  (tmr_value),
		.i_run    (tmr_run),
		.o_done   (tmr_done)
	);

	// ************************************************
	// output decode
	// ************************************************
	// gate on only in charging states or under boost, forced off by a pause
	assign gate_on = pin_s.charge_pause_n && (boost_d || state_d == ST_CONDITION ||
		state_d == ST_FAST || state_d == ST_TOPOFF);
	// first indicator: solid while charging, blinks on every defect
	assign chg_low = boost_d || pull(state_d == ST_QUALIFY || state_d == ST_CONDITION ||
		state_d == ST_FAST || state_d == ST_CHECK,
		state_d == ST_COND_FAIL || state_d == ST_DEFECT || state_d == ST_FAULT,
		blink_q);
	// second indicator: battery full, or blinking on a fault
	assign full_low = boost_d || pull(state_d == ST_TOPOFF || state_d == ST_MONITOR,
		state_d == ST_FAULT, blink_q);
	// voltage target by mode and select
	assign vout_d = (state_d == ST_CONDITION) ? VOUT_4V10 :
		(state_d == ST_MONITOR) ? (pin_s.voltage_select ? VOUT_4V09 : VOUT_3V84) :
		(pin_s.voltage_select ? VOUT_4V20 : VOUT_4V10);
	// sense target: boost beats conditioning beats fast
	assign isense_d = boost_d ? ISENSE_900MV :
		(state_d == ST_CONDITION) ? ISENSE_50MV : ISENSE_500MV;

	// ************************************************
	// registers
	// ************************************************
	// sequencer state and mode memories
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q  <= ST_RESET;
			boost_q  <= 1'b0;
			paused_q <= 1'b0;
			armed_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			boost_q  <= boost_d;
			paused_q <= paused_d;
			armed_q  <= 1'b1;
		end
	end

	// free-running blink, so every blinking indicator shares one phase
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			blink_cnt_q <= '0;
			blink_q     <= BLINK_RST;
		end else if (blink_cnt_q == P_BLINK_CYCLES - TIMER_W'(1)) begin
			blink_cnt_q <= '0;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + TIMER_W'(1);
		end
	end

	// registered outputs, aligned with state_q
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pass_gate_drive       <= GATE_RST;
			o_vout_sel              <= VOUT_4V20;
			o_isense_sel            <= ISENSE_500MV;
			o_ov_high               <= 1'b0;
			o_charge_indicator      <= 1'b0;
			o_charge_indicator_oe_n <= OE_N_RST;
			o_full_indicator        <= 1'b0;
			o_full_indicator_oe_n   <= OE_N_RST;
			o_mode                  <= ST_RESET;
		end else begin
			o_pass_gate_drive       <= gate_on;
			o_vout_sel              <= vout_d;
			o_isense_sel            <= isense_d;
			o_ov_high               <= pin_s.voltage_select;
			o_charge_indicator      <= 1'b0;
			o_charge_indicator_oe_n <= ~chg_low;
			o_full_indicator        <= 1'b0;
			o_full_indicator_oe_n   <= ~full_low;
			o_mode                  <= state_d;
		end
	end

	// ************************************************
	// assertions
	// ************************************************
	standby_hold_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(state_q == ST_STANDBY && !pin_s.enable) |=> (state_q == ST_STANDBY)
	) else $error("standby left while enable low");

	boost_refuse_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(cmp_s.bat_le_2v50 || paused_q) |=> !boost_q
	) else $error("boost taken while refused");

	boost_leds_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		boost_q |-> (!o_charge_indicator_oe_n && !o_full_indicator_oe_n)
	) else $error("indicators not low in boost");

	standby_vout_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(o_mode == ST_STANDBY) |->
		o_vout_sel == ($past(pin_s.voltage_select) ? VOUT_4V20 : VOUT_4V10)
	) else $error("wrong standby voltage target");

	standby_off_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(state_q == ST_STANDBY && !boost_q) |->
		(!o_pass_gate_drive && o_charge_indicator_oe_n && o_full_indicator_oe_n)
	) else $error("standby not idle");

	qualify_out_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(state_q == ST_QUALIFY && !boost_q) |-> (!o_pass_gate_drive && !o_charge_indicator_oe_n)
	) else $error("qualification outputs wrong");

	fault_entry_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(fault_hit && pin_s.enable) |=>
		(state_q == ST_FAULT && !o_pass_gate_drive) ##1 !o_pass_gate_drive
	) else $error("protection trip not taken");

	fault_stay_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(state_q == ST_FAULT && pin_s.enable) |=> (state_q == ST_FAULT)
	) else $error("fault left with enable high");

	pause_gate_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		!pin_s.charge_pause_n |=> !o_pass_gate_drive
	) else $error("gate on while paused");

	reset_gate_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		(state_q == ST_RESET) |-> (!o_pass_gate_drive && !boost_q)
	) else $error("gate on during reset state");

	boost_target_a: assert property (
		@(posedge i_clock) disable iff (!i_arst_n)
		boost_q |-> (o_isense_sel == ISENSE_900MV)
	) else $error("boost sense target wrong");
endmodule

// File: core/lcs_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module lcs_sync
	import lcs_pkg::*;
#(
	parameter int W = 1 // number of levels
) (
	input  wire logic         i_clock,   // core clock
	input  wire logic         i_arst_n,  // async reset, active low
	input  wire logic [W-1:0] i_async,   // levels from pins
	output logic      [W-1:0] o_sync     // levels safe to use
);
	// ************************************************
	// two stages
	// ************************************************
	logic [W-1:0] meta_q; // first stage, read only by the second

	if (W < 1) begin : g_chk
		$error("lcs_sync needs at least one bit");
	end

	// stage one feeds stage two and nothing else
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_q <= {W{SYNC_RST}};
			o_sync <= {W{SYNC_RST}};
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// File: core/lcs_timer.sv
// loadable down counter for the long sequencing intervals
`timescale 1ns/1ps
module lcs_timer
	import lcs_pkg::*;
#(
	parameter int W = TIMER_W // counter width
) (
	input  wire logic         i_clock,  // core clock
	input  wire logic         i_arst_n, // async reset, active low
	input  wire logic         i_load,   // restart with i_value
	input  wire logic [W-1:0] i_value,  // cycles to run
	input  wire logic         i_run,    // count this cycle
	output logic              o_done    // interval elapsed
);
	// ************************************************
	// counter
	// ************************************************
	logic [W-1:0] count_q; // cycles left
	logic [W-1:0] count_d; // next count

	if (W < 2) begin : g_chk
		$error("lcs_timer width too small");
	end

	// load wins over counting; stalled runs simply freeze the interval
	assign count_d = i_load ? i_value :
		(i_run && count_q != '0) ? count_q - W'(1) : count_q;
	assign o_done  = (count_q == '0);

	// counter register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

// File: sim/lcs_pack_model.sv
// behavioural model of the pack detector, battery and comparators
`timescale 1ns/1ps
module lcs_pack_model
	import lcs_pkg::*;
(
	input  wire logic      i_pack,  // pack seated in the charger
	input  wire lcs_pins_s i_ctl,   // host control levels
	input  wire lcs_cmp_s  i_cmp,   // battery condition to present
	input  wire logic      i_gate,  // pass gate drive from the sequencer
	output lcs_pins_s      o_pins,  // pins as the sequencer sees them
	output lcs_cmp_s       o_cmp    // comparator flags
);
	// ************************************************
	// pins and flags
	// ************************************************
	// enable follows the pack only, so it stays low with no pack
	always_comb begin
		o_pins        = i_ctl;
		o_pins.enable = i_pack;
	end

	// no current flows with the gate off, so an overcurrent flag cannot persist;
	// this makes the fault latch earn its keep
	always_comb begin
		o_cmp             = i_cmp;
		o_cmp.sense_gt_1v = i_cmp.sense_gt_1v & i_gate;
	end
endmodule

// File: sim/lcs_sequencer_bench.sv
// self-checking bench of the charge sequencer
`timescale 1ns/1ps
module lcs_sequencer_bench;
	import lcs_pkg::*;
	// one step of stimulus and the outputs it should give
	typedef struct {
		logic [3:0]  pins; // enable, boost, select, pause_n
		logic [8:0]  cmp;  // comparator flags
		int          wt;   // cycles to settle
		lcs_state_e  md;   // expected state
		int          g;    // expected gate
		int          co;   // charge indicator oe_n
		int          fo;   // full indicator oe_n
		lcs_vout_e   v;    // expected voltage target
		lcs_isense_e is;   // expected sense target
		int          chk;  // bit0 voltage, bit1 sense target
		int          blk;  // 0 steady, 1 both blink, 2 first blinks, 3 skip
	} lcs_row_s;
	logic        i_clock;   // core clock
	logic        i_arst_n;  // reset, active low
	logic        pack;      // pack present
	lcs_pins_s   ctl;       // control levels
	lcs_cmp_s    cmd;       // battery condition
	lcs_pins_s   pins;      // pins after the model
	lcs_cmp_s    cmp;       // flags after the model
	logic        o_g;       // pass gate
	lcs_vout_e   o_v;       // voltage target
	lcs_isense_e o_is;      // sense target
	logic        o_ov;      // threshold select
	logic        o_c;       // charge oe_n
	logic        o_f;       // full oe_n
	logic        o_cl;      // charge open-drain level
	logic        o_fl;      // full open-drain level
	lcs_state_e  o_md;      // state
	int          n_mismatch; // mismatches
	int          cmp_count;  // comparisons
	int          cyc;        // cycle count
	lcs_row_s    rows[30];   // sequence table
	lcs_pack_model pm_u (.i_pack(pack), .i_ctl(ctl), .i_cmp(cmd), .i_gate(o_g),
		.o_pins(pins), .o_cmp(cmp));
	lcs_sequencer #(.P_QUAL_CYCLES(40'h8), .P_SUPPLY_CYCLES(40'h8), .P_CHECK_CYCLES(40'h8),
		.P_HOUR_CYCLES(40'h14), .P_BLINK_CYCLES(40'h4)) dut_u (.i_clock(i_clock),
		.i_arst_n(i_arst_n), .i_pins(pins), .i_cmp(cmp), .o_pass_gate_drive(o_g),
		.o_vout_sel(o_v), .o_isense_sel(o_is), .o_ov_high(o_ov), .o_charge_indicator(o_cl),
		.o_charge_indicator_oe_n(o_c), .o_full_indicator(o_fl), .o_full_indicator_oe_n(o_f),
		.o_mode(o_md));
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// ************************************************
	// helpers
	// ************************************************
	task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// counts indicator toggles over 32 cycles; half period 4 gives exactly 8
	task automatic check_blink(input logic [1:0] kind);
		int nc;
		int nf;
		logic pc;
		logic pf;
		nc = 0;
		nf = 0;
		pc = o_c;
		pf = o_f;
		repeat (32) begin
			@(posedge i_clock);
			#1;
			if (o_c !== pc) nc++;
			if (o_f !== pf) nf++;
			pc = o_c;
			pf = o_f;
		end
		check("charge blink", 4'(nc), 4'h8);
		check("full blink", 4'(nf), (kind == 2'h1) ? 4'h8 : 4'h0);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ************************************************
	// sequence
	// ************************************************
	initial begin
		rows = '{
			'{4'h2, 9'h100, 14, ST_STANDBY, 0, 1, 1, VOUT_4V20, ISENSE_50MV, 1, 0},
			'{4'h0, 9'h100, 6, ST_STANDBY, 0, 1, 1, VOUT_4V10, ISENSE_50MV, 1, 0},
			'{4'hB, 9'h100, 4, ST_QUALIFY, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hB, 9'h100, 14, ST_CONDITION, 1, 0, 1, VOUT_4V10, ISENSE_50MV, 3, 0},
			'{4'hB, 9'h140, 6, ST_FAST, 1, 0, 1, VOUT_4V20, ISENSE_500MV, 3, 0},
			'{4'hB, 9'h148, 6, ST_CHECK, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hB, 9'h14A, 12, ST_TOPOFF, 1, 1, 0, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hB, 9'h14A, 24, ST_MONITOR, 0, 1, 0, VOUT_4V09, ISENSE_50MV, 1, 0},
			'{4'hB, 9'h152, 6, ST_FAST, 1, 0, 1, VOUT_4V20, ISENSE_500MV, 3, 0},
			'{4'hF, 9'h152, 6, ST_FAST, 1, 0, 0, VOUT_4V20, ISENSE_900MV, 2, 0},
			'{4'hA, 9'h152, 6, ST_FAST, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 3},
			'{4'hB, 9'h152, 6, ST_FAST, 1, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hF, 9'h152, 6, ST_FAST, 1, 0, 1, VOUT_4V20, ISENSE_500MV, 2, 0},
			'{4'hB, 9'h153, 6, ST_FAULT, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 1},
			'{4'hB, 9'h152, 10, ST_FAULT, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 3},
			'{4'h3, 9'h100, 6, ST_STANDBY, 0, 1, 1, VOUT_4V20, ISENSE_50MV, 1, 0},
			'{4'h7, 9'h180, 6, ST_STANDBY, 0, 1, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'h7, 9'h100, 6, ST_STANDBY, 1, 0, 0, VOUT_4V20, ISENSE_900MV, 2, 0},
			'{4'hB, 9'h140, 16, ST_FAST, 1, 0, 1, VOUT_4V20, ISENSE_500MV, 2, 0},
			'{4'hB, 9'h148, 16, ST_DEFECT, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 2},
			'{4'h3, 9'h100, 6, ST_STANDBY, 0, 1, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hB, 9'h100, 40, ST_COND_FAIL, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 2},
			'{4'h3, 9'h100, 6, ST_STANDBY, 0, 1, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hB, 9'h120, 16, ST_FAULT, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 1},
			'{4'h3, 9'h100, 6, ST_STANDBY, 0, 1, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hB, 9'h140, 16, ST_FAST, 1, 0, 1, VOUT_4V20, ISENSE_500MV, 0, 0},
			'{4'hB, 9'h144, 6, ST_FAULT, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 1},
			'{4'h3, 9'h100, 6, ST_STANDBY, 0, 1, 1, VOUT_4V20, ISENSE_50MV, 0, 0},
			'{4'hB, 9'h140, 16, ST_FAST, 1, 0, 1, VOUT_4V20, ISENSE_500MV, 0, 0},
			'{4'hF, 9'h141, 3, ST_FAULT, 0, 0, 1, VOUT_4V20, ISENSE_50MV, 0, 1}
		};
		n_mismatch = 0;
		cmp_count = 0;
		cyc = 0;
		i_arst_n = 1'b0;
		pack = 1'b0;
		ctl = lcs_pins_s'(4'h3);
		cmd = lcs_cmp_s'(9'h100);
		repeat (8) @(posedge i_clock);
		i_arst_n <= 1'b1;
		foreach (rows[k]) begin
			@(posedge i_clock);
			pack <= rows[k].pins[3];
			ctl <= lcs_pins_s'(rows[k].pins);
			cmd <= lcs_cmp_s'(rows[k].cmp);
			repeat (rows[k].wt) @(posedge i_clock);
			#1;
			check("mode", o_md, rows[k].md);
			check("gate", 4'(o_g), 4'(rows[k].g));
			check("ov select", 4'(o_ov), 4'(rows[k].pins[1]));
			check("levels", {2'h0, o_cl, o_fl}, 4'h0);
			if (rows[k].chk[0]) check("vout", 4'(o_v), 4'(rows[k].v));
			if (rows[k].chk[1]) check("isense", 4'(o_is), 4'(rows[k].is));
			if (rows[k].blk == 0) begin
				check("charge oe_n", 4'(o_c), 4'(rows[k].co));
				check("full oe_n", 4'(o_f), 4'(rows[k].fo));
			end
			if (rows[k].blk == 1 || rows[k].blk == 2) begin
				check_blink(2'(rows[k].blk));
			end
		end
		// mid-run reset with a weak supply: held until supply good 8 cycles
		@(posedge i_clock);
		pack <= 1'b0;
		cmd <= lcs_cmp_s'(9'h000);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		#1;
		check("reset mode", o_md, ST_RESET);
		check("reset gate", 4'(o_g), 4'h0);
		check("reset oe_n", {2'h0, o_c, o_f}, 4'h3);
		check("reset levels", {2'h0, o_cl, o_fl}, 4'h0);
		@(posedge i_clock);
		i_arst_n <= 1'b1;
		repeat (20) @(posedge i_clock);
		#1;
		check("no supply", o_md, ST_RESET);
		@(posedge i_clock);
		cmd <= lcs_cmp_s'(9'h100);
		repeat (6) @(posedge i_clock);
		#1;
		check("settling", o_md, ST_RESET);
		repeat (10) @(posedge i_clock);
		#1;
		check("settled", o_md, ST_STANDBY);
		print_verdict();
	end
endmodule
